// file: sfe_map.vh
// constants for the serial flash front end
`ifndef SFE_MAP_VH
`define SFE_MAP_VH
// opcodes
`define SFE_OP_WREN 8'h06
`define SFE_OP_WRDI 8'h04
`define SFE_OP_RDSR1 8'h05
`define SFE_OP_RDSR2 8'h35
`define SFE_OP_WRSR 8'h01
`define SFE_OP_READ 8'h03
`define SFE_OP_FAST 8'h0B
`define SFE_OP_DOUT2 8'h3B
`define SFE_OP_DIO2 8'hBB
`define SFE_OP_QOUT 8'h6B
`define SFE_OP_QIO 8'hEB
`define SFE_OP_QWORD 8'hE7
`define SFE_OP_QOCT 8'hE3
`define SFE_OP_PP 8'h02
`define SFE_OP_QPP 8'h32
`define SFE_OP_SE 8'h20
`define SFE_OP_BE32 8'h52
`define SFE_OP_BE64 8'hD8
`define SFE_OP_CE1 8'hC7
`define SFE_OP_CE2 8'h60
`define SFE_OP_PD 8'hB9
`define SFE_OP_REL 8'hAB
`define SFE_OP_NONE 8'h00
// lane widths and dummy clocks
`define SFE_LW1 3'h1
`define SFE_LW2 3'h2
`define SFE_LW4 3'h4
`define SFE_DUM_NONE 4'h0
`define SFE_DUM_FAST 4'h8
`define SFE_DUM_DIO2 4'h4
`define SFE_DUM_QIO 4'h6
`define SFE_DUM_QWORD 4'h4
`define SFE_DUM_QOCT 4'h2
`define SFE_DUM_LAST 4'h1
`define SFE_ADDR_LAST 2'h2
// array geometry, 20-bit byte addresses
`define SFE_ARRAY_BASE 20'h00000
`define SFE_ARRAY_TOP 20'h7FFFF
`define SFE_ARRAY_SZ 20'h80000
`define SFE_ONE20 20'h00001
`define SFE_SEC4K 20'h01000
`define SFE_BLK32 20'h08000
`define SFE_BLK64 20'h10000
`define SFE_PAGE_M 20'h000FF
`define SFE_SEC_M 20'h00FFF
`define SFE_B32_M 20'h07FFF
`define SFE_B64_M 20'h0FFFF
// timing
`define SFE_CLK_NS 10
`define SFE_TPUW_NS 10000
`define SFE_TPUW_CYC ((`SFE_TPUW_NS + `SFE_CLK_NS - 1) / `SFE_CLK_NS)
`define SFE_FIFO_DEPTH 8
`endif

// file: sfe_front_end.v
// serial flash command front end with its page data fifo
// Overview of operation
// - sample input lanes on serial clock rise
// - drive output lanes on serial clock fall
// - clock modes 0 and 3 both work
// - dual reads use lanes 0 and 1
// - quad commands use all four lanes
// - quad opcodes need quad mode enable set
// - pause starts when clock low, hold low
// - pause ends when clock low, hold high
// - paused: outputs float, clock and input ignored
// - no pause while quad mode enabled
// - reset blocks all, then write-type lockout delay
// - writes need write enable latch set first
// - latch clears when write operation starts
// - status bit 1 is the latch
// - status bit 0 is busy
// - busy: only status reads
// - status bits 4:2 protect field, reset zero
// - protect sector up to whole array
// - powered down: only release is accepted
// - status write gated by lock mode, latch, pin
// - status bit 9 is quad mode enable
// - refuse program/erase touching protected region
// - hardware lock with pin low refuses status write unless quad mode enabled
// - no command before first select fall
`timescale 1ns/1ns
`include "sfe_map.vh"

////////////////////////////////////////////////////////////////////////////////
// shift-down fifo: head always sits in slot 0, so its outputs are flops
module sfe_fifo #(
  parameter W = 8,
  parameter D = 8,
  parameter AW = 3
) (
  input wire clk,
  input wire rst,
  input wire flush,
  input wire in_valid,
  input wire [W-1:0] in_data,
  output wire in_ready,
  output wire out_valid,
  output wire [W-1:0] out_data,
  input wire out_ready
);
  localparam [AW:0] DEPTH = D;
  localparam [AW:0] ZERO = 0;
  localparam [AW:0] ONE = 1;
  reg [W-1:0] mem_reg [0:D-1];
  reg [AW:0] cnt_reg;
  reg full_reg;
  reg nemp_reg;
  integer i;
  wire push = in_valid & ~full_reg;
  wire pop = out_ready & nemp_reg;
  wire [AW:0] cnt_next = cnt_reg + (push ? ONE : ZERO) - (pop ? ONE : ZERO);
  wire [AW:0] widx = pop ? cnt_reg - ONE : cnt_reg;
  assign in_ready = ~full_reg;
  assign out_valid = nemp_reg;
  assign out_data = mem_reg[0];
  // storage shifts toward the head on pop; the write lands behind the last entry
  always @(posedge clk) begin
    for (i = 0; i < D - 1; i = i + 1) begin
      if (pop) begin
        mem_reg[i] <= mem_reg[i + 1];
      end
    end
    for (i = 0; i < D; i = i + 1) begin
      if (push && widx == i[AW:0]) begin
        mem_reg[i] <= in_data;
      end
    end
  end
  // occupancy and flags
  always @(posedge clk) begin
    if (rst || flush) begin
      cnt_reg <= ZERO;
      full_reg <= 1'b0;
      nemp_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      full_reg <= (cnt_next == DEPTH);
      nemp_reg <= (cnt_next != ZERO);
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module sfe_front_end (
  input wire clk,
  input wire rst,
  input wire cs_n,
  input wire sclk,
  input wire lane0_in,
  output reg lane0_out,
  output reg lane0_oe_n,
  input wire lane1_in,
  output reg lane1_out,
  output reg lane1_oe_n,
  input wire lane2_in,
  output reg lane2_out,
  output reg lane2_oe_n,
  input wire lane3_in,
  output reg lane3_out,
  output reg lane3_oe_n,
  output reg op_start,
  output reg [7:0] op_code,
  output reg [23:0] op_addr,
  input wire op_done,
  output wire [23:0] array_addr,
  input wire [7:0] array_rd_data,
  output wire [7:0] array_wr_data,
  output wire array_wr_valid,
  input wire array_wr_ready,
  output wire busy,
  output reg data_overrun
);
  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_OPC = 7'h02;
  localparam [6:0] S_ADDR = 7'h04;
  localparam [6:0] S_DUM = 7'h08;
  localparam [6:0] S_DIN = 7'h10;
  localparam [6:0] S_DOUT = 7'h20;
  localparam [6:0] S_SKIP = 7'h40;
  localparam integer PUW_INT = `SFE_TPUW_CYC;
  localparam [15:0] PUW_CYC = PUW_INT[15:0];

  reg [5:0] sync1_reg;
  reg [5:0] sync2_reg;
  reg sclk_prev_reg;
  reg cs_prev_reg;
  reg paused_reg;
  reg [15:0] lock_cnt_reg;
  reg lock_done_reg;
  reg [6:0] state_reg;
  reg [7:0] cmd_reg;
  reg cmd_rd_reg;
  reg [2:0] lw_reg;
  reg [2:0] dlw_reg;
  reg [3:0] dcnt_reg;
  reg [3:0] icnt_reg;
  reg [7:0] in_sh_reg;
  reg [3:0] ocnt_reg;
  reg [7:0] osh_reg;
  reg [3:0] obits_reg;
  reg dgo_reg;
  reg [1:0] acnt_reg;
  reg addr_done_reg;
  reg [23:0] addr_reg;
  reg [1:0] din_cnt_reg;
  reg [7:0] wb0_reg;
  reg [7:0] wb1_reg;
  reg busy_reg;
  reg wel_reg;
  reg pd_reg;
  reg [2:0] bp_reg;
  reg tb_reg;
  reg sec_reg;
  reg srp0_reg;
  reg srp1_reg;
  reg qe_reg;
  reg [2:0] lb_reg;
  reg cmp_reg;
  reg push_reg;
  reg [7:0] push_data_reg;
  reg flush_reg;
  wire fifo_in_ready;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; only the second stage is ever read
  always @(posedge clk) begin
    sync1_reg <= {cs_n, sclk, lane3_in, lane2_in, lane1_in, lane0_in};
    sync2_reg <= sync1_reg;
    sclk_prev_reg <= sync2_reg[4];
    cs_prev_reg <= sync2_reg[5];
  end

  wire cs_n_s = sync2_reg[5];
  wire sclk_s = sync2_reg[4];
  wire l3 = sync2_reg[3];
  wire l2 = sync2_reg[2];
  wire l1 = sync2_reg[1];
  wire l0 = sync2_reg[0];
  wire cs_fall = cs_prev_reg & ~cs_n_s;
  wire cs_rise = ~cs_prev_reg & cs_n_s;
  wire act_rise = sclk_s & ~sclk_prev_reg & ~paused_reg & ~cs_n_s;
  wire act_fall = ~sclk_s & sclk_prev_reg & ~paused_reg & ~cs_n_s;

  // edge detection works from either idle clock level
  // pause follows hold only while the clock is low, which covers both the
  // immediate case and the wait for the next falling edge
  always @(posedge clk) begin
    if (rst || cs_n_s || qe_reg) begin
      paused_reg <= 1'b0;
    end else if (!sclk_s) begin
      paused_reg <= ~l3;
    end
  end

  // write-type lockout after internal reset release
  always @(posedge clk) begin
    if (rst) begin
      lock_cnt_reg <= 16'h0000;
      lock_done_reg <= 1'b0;
    end else if (!lock_done_reg) begin
      lock_cnt_reg <= lock_cnt_reg + 16'h0001;
      lock_done_reg <= (lock_cnt_reg == PUW_CYC);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status word and protection check
  wire [15:0] sr = {1'b0, cmp_reg, lb_reg, 1'b0, qe_reg, srp1_reg, srp0_reg,
                    sec_reg, tb_reg, bp_reg, wel_reg, busy_reg};

  // true when any byte of lo..hi is read-only under the current settings
  function prot_hit;
    input sec;
    input tb;
    input cmp;
    input [2:0] bp;
    input [19:0] lo;
    input [19:0] hi;
    reg [19:0] sz;
    reg [19:0] plo;
    reg [19:0] phi;
    reg none;
    reg all;
    begin
      none = (bp == 3'h0);
      all = sec ? (bp == 3'h7) : bp[2];
      if (sec) begin
        sz = bp[2] ? `SFE_BLK32 : (`SFE_SEC4K << (bp[1:0] - 2'h1));
      end else begin
        sz = `SFE_BLK64 << (bp[1:0] - 2'h1);
      end
      plo = tb ? `SFE_ARRAY_BASE : `SFE_ARRAY_SZ - sz;
      phi = tb ? sz - `SFE_ONE20 : `SFE_ARRAY_TOP;
      if (all) begin
        plo = `SFE_ARRAY_BASE;
        phi = `SFE_ARRAY_TOP;
      end
      if (cmp) begin
        prot_hit = none | (lo < plo) | (hi > phi);
      end else begin
        prot_hit = ~none & (lo <= phi) & (hi >= plo);
      end
    end
  endfunction

  // target region of the pending program or erase
  reg [19:0] tmask;
  always @* begin
    case (cmd_reg)
      `SFE_OP_PP, `SFE_OP_QPP: tmask = `SFE_PAGE_M;
      `SFE_OP_SE: tmask = `SFE_SEC_M;
      `SFE_OP_BE32: tmask = `SFE_B32_M;
      `SFE_OP_BE64: tmask = `SFE_B64_M;
      default: tmask = `SFE_ARRAY_TOP;
    endcase
  end
  wire [19:0] t_lo = {1'b0, addr_reg[18:0]} & ~tmask;
  wire [19:0] t_hi = t_lo | tmask;
  wire prot = prot_hit(sec_reg, tb_reg, cmp_reg, bp_reg, t_lo, t_hi);
  wire wr_ok = lock_done_reg & wel_reg & ~busy_reg;
  // write-protect pin only counts while lane 2 is not a data lane
  wire sr_wr_ok = ~srp1_reg & ~(srp0_reg & ~qe_reg & ~l2);

  wire [7:0] in_byte = (lw_reg == `SFE_LW4) ? {in_sh_reg[3:0], l3, l2, l1, l0} :
                       (lw_reg == `SFE_LW2) ? {in_sh_reg[5:0], l1, l0} :
                       {in_sh_reg[6:0], l0};
  wire [3:0] icnt_inc = icnt_reg + {1'b0, lw_reg};
  wire [3:0] ocnt_inc = ocnt_reg + {1'b0, lw_reg};
  wire byte_done = icnt_inc[3];
  wire [7:0] src = (cmd_reg == `SFE_OP_RDSR1) ? sr[7:0] :
                   (cmd_reg == `SFE_OP_RDSR2) ? sr[15:8] : array_rd_data;
  wire [7:0] cur = (ocnt_reg == 4'h0) ? src : osh_reg;
  wire quad_op = (in_byte == `SFE_OP_QOUT) | (in_byte == `SFE_OP_QIO) |
                 (in_byte == `SFE_OP_QWORD) | (in_byte == `SFE_OP_QOCT) |
                 (in_byte == `SFE_OP_QPP);
  wire rd_only = (in_byte == `SFE_OP_RDSR1) | (in_byte == `SFE_OP_RDSR2);

  ////////////////////////////////////////////////////////////////////////////
  // command sequencer
  always @(posedge clk) begin
    op_start <= 1'b0;
    flush_reg <= 1'b0;
    push_reg <= 1'b0;
    if (rst) begin
      state_reg <= S_IDLE;
      cmd_reg <= `SFE_OP_NONE;
      cmd_rd_reg <= 1'b0;
      lw_reg <= `SFE_LW1;
      dlw_reg <= `SFE_LW1;
      dcnt_reg <= `SFE_DUM_NONE;
      icnt_reg <= 4'h0;
      in_sh_reg <= 8'h00;
      ocnt_reg <= 4'h0;
      osh_reg <= 8'h00;
      obits_reg <= 4'h0;
      dgo_reg <= 1'b0;
      acnt_reg <= 2'h0;
      addr_done_reg <= 1'b0;
      addr_reg <= 24'h000000;
      din_cnt_reg <= 2'h0;
      wb0_reg <= 8'h00;
      wb1_reg <= 8'h00;
      busy_reg <= 1'b0;
      wel_reg <= 1'b0;
      pd_reg <= 1'b0;
      bp_reg <= 3'h0;
      tb_reg <= 1'b0;
      sec_reg <= 1'b0;
      srp0_reg <= 1'b0;
      srp1_reg <= 1'b0;
      qe_reg <= 1'b0;
      lb_reg <= 3'h0;
      cmp_reg <= 1'b0;
      op_code <= `SFE_OP_NONE;
      op_addr <= 24'h000000;
      push_data_reg <= 8'h00;
      data_overrun <= 1'b0;
    end else begin
      if (op_done && busy_reg) begin
        busy_reg <= 1'b0;
        wel_reg <= 1'b0;
      end
      if (push_reg && !fifo_in_ready) begin
        data_overrun <= 1'b1;
      end
      // leaving select drops everything; a new frame needs a select fall
      if (cs_n_s) begin
        state_reg <= S_IDLE;
        dgo_reg <= 1'b0;
      end else if (cs_fall) begin
        state_reg <= S_OPC;
        cmd_reg <= `SFE_OP_NONE;
        lw_reg <= `SFE_LW1;
        icnt_reg <= 4'h0;
        ocnt_reg <= 4'h0;
        acnt_reg <= 2'h0;
        addr_done_reg <= 1'b0;
        din_cnt_reg <= 2'h0;
      end else if (act_rise && state_reg != S_DOUT && state_reg != S_SKIP) begin
        in_sh_reg <= in_byte;
        icnt_reg <= byte_done ? 4'h0 : icnt_inc;
        case (state_reg)
          S_OPC: begin
            if (byte_done) begin
              cmd_reg <= in_byte;
              cmd_rd_reg <= 1'b1;
              dlw_reg <= `SFE_LW1;
              dcnt_reg <= `SFE_DUM_NONE;
              state_reg <= S_ADDR;
              if (pd_reg && in_byte != `SFE_OP_REL) begin
                cmd_reg <= `SFE_OP_NONE;
                state_reg <= S_SKIP;
              end else if (busy_reg && !rd_only) begin
                cmd_reg <= `SFE_OP_NONE;
                state_reg <= S_SKIP;
              end else if (quad_op && !qe_reg) begin
                cmd_reg <= `SFE_OP_NONE;
                state_reg <= S_SKIP;
              end else begin
                case (in_byte)
                  `SFE_OP_REL: begin
                    pd_reg <= 1'b0;
                    state_reg <= S_SKIP;
                  end
                  `SFE_OP_RDSR1, `SFE_OP_RDSR2: state_reg <= S_DOUT;
                  `SFE_OP_READ: dlw_reg <= `SFE_LW1;
                  `SFE_OP_FAST: dcnt_reg <= `SFE_DUM_FAST;
                  `SFE_OP_DOUT2: begin
                    dcnt_reg <= `SFE_DUM_FAST;
                    dlw_reg <= `SFE_LW2;
                  end
                  `SFE_OP_DIO2: begin
                    lw_reg <= `SFE_LW2;
                    dlw_reg <= `SFE_LW2;
                    dcnt_reg <= `SFE_DUM_DIO2;
                  end
                  `SFE_OP_QOUT: begin
                    dcnt_reg <= `SFE_DUM_FAST;
                    dlw_reg <= `SFE_LW4;
                  end
                  `SFE_OP_QIO, `SFE_OP_QWORD, `SFE_OP_QOCT: begin
                    lw_reg <= `SFE_LW4;
                    dlw_reg <= `SFE_LW4;
                    dcnt_reg <= (in_byte == `SFE_OP_QIO) ? `SFE_DUM_QIO :
                                (in_byte == `SFE_OP_QWORD) ? `SFE_DUM_QWORD : `SFE_DUM_QOCT;
                  end
                  `SFE_OP_PP, `SFE_OP_SE, `SFE_OP_BE32, `SFE_OP_BE64: cmd_rd_reg <= 1'b0;
                  `SFE_OP_QPP: begin
                    cmd_rd_reg <= 1'b0;
                    dlw_reg <= `SFE_LW4;
                  end
                  `SFE_OP_WRSR: state_reg <= S_DIN;
                  default: state_reg <= S_SKIP;
                endcase
              end
            end
          end
          S_ADDR: begin
            if (byte_done) begin
              addr_reg <= {addr_reg[15:0], in_byte};
              acnt_reg <= acnt_reg + 2'h1;
              if (acnt_reg == `SFE_ADDR_LAST) begin
                addr_done_reg <= 1'b1;
                lw_reg <= dlw_reg;
                if (cmd_rd_reg) begin
                  state_reg <= (dcnt_reg == `SFE_DUM_NONE) ? S_DOUT : S_DUM;
                end else if (cmd_reg == `SFE_OP_PP || cmd_reg == `SFE_OP_QPP) begin
                  state_reg <= S_DIN;
                end else begin
                  state_reg <= S_SKIP;
                end
              end
            end
          end
          S_DUM: begin
            icnt_reg <= 4'h0;
            dcnt_reg <= dcnt_reg - 4'h1;
            if (dcnt_reg == `SFE_DUM_LAST) begin
              state_reg <= S_DOUT;
            end
          end
          S_DIN: begin
            if (byte_done) begin
              if (din_cnt_reg != 2'h3) begin
                din_cnt_reg <= din_cnt_reg + 2'h1;
              end
              if (din_cnt_reg == 2'h0) begin
                wb0_reg <= in_byte;
              end
              if (din_cnt_reg == 2'h1) begin
                wb1_reg <= in_byte;
              end
              // only bytes of a program that will be allowed reach the buffer
              if (cmd_reg != `SFE_OP_WRSR && wr_ok && !prot) begin
                push_reg <= 1'b1;
                push_data_reg <= in_byte;
              end
            end
          end
          default: state_reg <= S_SKIP;
        endcase
      end else if (act_fall && state_reg == S_DOUT) begin
        // new bits leave on the falling edge, ready for the host's next rise
        dgo_reg <= 1'b1;
        osh_reg <= (lw_reg == `SFE_LW4) ? {cur[3:0], 4'h0} :
                   (lw_reg == `SFE_LW2) ? {cur[5:0], 2'h0} : {cur[6:0], 1'b0};
        obits_reg <= (lw_reg == `SFE_LW4) ? cur[7:4] :
                     (lw_reg == `SFE_LW2) ? {2'h0, cur[7:6]} : {2'h0, cur[7], 1'b0};
        ocnt_reg <= ocnt_inc[3] ? 4'h0 : ocnt_inc;
        if (ocnt_inc[3] && cmd_rd_reg) begin
          addr_reg <= addr_reg + 24'h000001;
        end
      end
      // execution only at select rise on a whole byte
      if (cs_rise && state_reg != S_IDLE && icnt_reg == 4'h0) begin
        case (cmd_reg)
          `SFE_OP_WREN: begin
            if (lock_done_reg) begin
              wel_reg <= 1'b1;
            end
          end
          `SFE_OP_WRDI: wel_reg <= 1'b0;
          `SFE_OP_PD: pd_reg <= 1'b1;
          `SFE_OP_WRSR: begin
            if (din_cnt_reg != 2'h0 && wr_ok && sr_wr_ok) begin
              bp_reg <= wb0_reg[4:2];
              tb_reg <= wb0_reg[5];
              sec_reg <= wb0_reg[6];
              srp0_reg <= wb0_reg[7];
              if (din_cnt_reg != 2'h1) begin
                srp1_reg <= wb1_reg[0];
                qe_reg <= wb1_reg[1];
                lb_reg <= lb_reg | wb1_reg[5:3];
                cmp_reg <= wb1_reg[6];
              end
              busy_reg <= 1'b1;
              wel_reg <= 1'b0;
              op_start <= 1'b1;
              op_code <= cmd_reg;
            end
          end
          `SFE_OP_PP, `SFE_OP_QPP, `SFE_OP_SE, `SFE_OP_BE32, `SFE_OP_BE64,
          `SFE_OP_CE1, `SFE_OP_CE2: begin
            if (wr_ok && !prot && (addr_done_reg || cmd_reg == `SFE_OP_CE1 ||
                cmd_reg == `SFE_OP_CE2) && (cmd_rd_reg || state_reg != S_DIN ||
                din_cnt_reg != 2'h0) && !(state_reg == S_ADDR)) begin
              busy_reg <= 1'b1;
              wel_reg <= 1'b0;
              op_start <= 1'b1;
              op_code <= cmd_reg;
              op_addr <= addr_reg;
            end else begin
              flush_reg <= 1'b1;
            end
          end
          default: cmd_reg <= cmd_reg;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // lane drivers: enables fall while driving; pause or deselect floats all
  wire drive = (state_reg == S_DOUT) & dgo_reg & ~paused_reg & ~cs_n_s;
  always @(posedge clk) begin
    if (rst) begin
      {lane3_out, lane2_out, lane1_out, lane0_out} <= 4'h0;
      {lane3_oe_n, lane2_oe_n, lane1_oe_n, lane0_oe_n} <= 4'hF;
    end else begin
      {lane3_out, lane2_out, lane1_out, lane0_out} <= obits_reg;
      lane1_oe_n <= ~drive;
      lane0_oe_n <= ~(drive & (lw_reg != `SFE_LW1));
      lane2_oe_n <= ~(drive & (lw_reg == `SFE_LW4));
      lane3_oe_n <= ~(drive & (lw_reg == `SFE_LW4));
    end
  end

  assign array_addr = addr_reg;
  assign busy = busy_reg;

  // program data buffer; the array engine drains it as bytes arrive
  sfe_fifo #(
    .W(8),
    .D(`SFE_FIFO_DEPTH),
    .AW(3)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .flush(flush_reg),
    .in_valid(push_reg),
    .in_data(push_data_reg),
    .in_ready(fifo_in_ready),
    .out_valid(array_wr_valid),
    .out_data(array_wr_data),
    .out_ready(array_wr_ready)
  );
endmodule

// file: sfe_host_model.sv
// behavioural spi host that drives the flash front end in clock mode 0
`timescale 1ns/1ns
module sfe_host_model (
  input wire clk,
  output logic cs_n,
  output logic sclk,
  output logic mosi,
  input wire miso
);
  // idle: deselected, serial clock parked low
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end
  ////////////////////////////////////////
  // one frame of n whole bytes, msb first, 16 clk per serial clock period
  // clock stays low at both select edges, so only mode 0 is exercised here
  task automatic frame(input int n, input logic [95:0] tx, output logic [7:0] rx);
    rx = 8'h00;
    @(negedge clk);
    cs_n = 1'b0;
    for (int i = 0; i < n * 8; i++) begin
      mosi = tx[95 - i];
      repeat (8) @(negedge clk);
      sclk = 1'b1;
      rx = {rx[6:0], miso};
      repeat (8) @(negedge clk);
      sclk = 1'b0;
    end
    repeat (8) @(negedge clk);
    cs_n = 1'b1;
    mosi = ~mosi; // released line does not keep its last bit
    repeat (8) @(negedge clk);
  endtask
endmodule

// file: sfe_front_end_asserts.sv
// port-level assertions for the serial flash front end
`timescale 1ns/1ns
module sfe_front_end_asserts (
  input wire clk,
  input wire rst,
  input wire cs_n,
  input wire lane0_oe_n,
  input wire lane1_oe_n,
  input wire lane2_oe_n,
  input wire lane3_oe_n,
  input wire op_start,
  input wire op_done,
  input wire busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // select high long enough for the synchroniser to see the frame end
  sequence s_idle;
    cs_n [*6];
  endsequence
  // an accepted operation is still busy on the next clock
  sequence s_launch;
    op_start ##1 busy;
  endsequence
  a_start_pulse: assert property (op_start |=> !op_start)
    else $error("start wider than one clock");
  a_start_at_end: assert property (op_start |-> cs_n)
    else $error("start while selected");
  a_start_busy: assert property (op_start |-> s_launch)
    else $error("start without busy");
  a_busy_cause: assert property ($rose(busy) |-> op_start)
    else $error("busy without start");
  a_busy_holds: assert property (busy && !op_done |=> busy)
    else $error("busy dropped early");
  a_done_clears: assert property (busy && op_done |=> !busy)
    else $error("busy stuck after done");
  a_busy_refuse: assert property (op_start |-> !$past(busy))
    else $error("start while busy");
  a_idle_float: assert property (s_idle |->
    lane0_oe_n && lane1_oe_n && lane2_oe_n && lane3_oe_n) else $error("lanes driven idle");
  a_reset_quiet: assert property ($fell(rst) |-> lane1_oe_n && !busy && !op_start)
    else $error("outputs active after reset");
endmodule
bind sfe_front_end sfe_front_end_asserts u_chk (.clk(clk), .rst(rst), .cs_n(cs_n),
  .lane0_oe_n(lane0_oe_n), .lane1_oe_n(lane1_oe_n), .lane2_oe_n(lane2_oe_n),
  .lane3_oe_n(lane3_oe_n), .op_start(op_start), .op_done(op_done), .busy(busy));

// file: sfe_front_end_tb.sv
// self-checking bench for the serial flash front end
`timescale 1ns/1ns
`include "sfe_map.vh"
module sfe_front_end_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic op_done = 1'b0;
  logic wr_ready = 1'b0;
  wire cs_n, sclk, mosi, l0o, l1o, l2o, l3o, l0e, l1e, l2e, l3e;
  wire op_start, wr_valid, busy, overrun;
  wire [7:0] op_code, wr_data;
  wire [23:0] op_addr;
  wire [23:0] rd_addr;
  int errors = 0;
  int checked = 0;
  int starts = 0;
  logic [7:0] rx;
  logic [7:0] popped [$];
  logic [7:0] row_op [4] = '{`SFE_OP_WRDI, `SFE_OP_WREN, `SFE_OP_WRDI, `SFE_OP_WREN};
  logic [7:0] row_sr [4] = '{8'h00, 8'h02, 8'h00, 8'h02};
  always #5 clk = ~clk;
  // count engine starts and collect what the engine pops from the fifo
  always @(posedge clk) begin
    if (op_start) starts <= starts + 1;
    if (wr_valid && wr_ready) popped.push_back(wr_data);
  end
  // released lanes float up to their pull-ups (protect and pause inactive)
  sfe_host_model host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .mosi(mosi), .miso(l1e ? 1'b1 : l1o));
  sfe_front_end DUT (.clk(clk), .rst(rst), .cs_n(cs_n), .sclk(sclk),
    .lane0_in(l0e ? mosi : l0o), .lane0_out(l0o), .lane0_oe_n(l0e),
    .lane1_in(l1e ? 1'b1 : l1o), .lane1_out(l1o), .lane1_oe_n(l1e),
    .lane2_in(l2e ? 1'b1 : l2o), .lane2_out(l2o), .lane2_oe_n(l2e),
    .lane3_in(l3e ? 1'b1 : l3o), .lane3_out(l3o), .lane3_oe_n(l3e),
    .op_start(op_start), .op_code(op_code), .op_addr(op_addr), .op_done(op_done),
    .array_addr(rd_addr), .array_rd_data(8'h5A), .array_wr_data(wr_data),
    .array_wr_valid(wr_valid), .array_wr_ready(wr_ready), .busy(busy), .data_overrun(overrun));
  ////////////////////////////////////////
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmd(input int n, input logic [95:0] tx);
    host.frame(n, tx, rx);
  endtask
  // status read: opcode byte, then one byte clocked back
  task automatic rdsr(input logic [7:0] exp);
    host.frame(2, {`SFE_OP_RDSR1, 88'h0}, rx);
    chk("status", {16'h0, exp}, {16'h0, rx});
  endtask
  task automatic done_pulse;
    @(negedge clk) op_done = 1'b1;
    @(negedge clk) op_done = 1'b0;
  endtask
  task automatic final_report;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (1010) @(negedge clk); // let the power-up write lockout run out
    for (int i = 0; i < 4; i++) begin
      cmd(1, {row_op[i], 88'h0});
      rdsr(row_sr[i]);
    end
    $display("latch rows done");
    // program 8 bytes while the engine stalls, so the fifo ends full
    cmd(12, {`SFE_OP_PP, 24'h000100, 64'h0011223344556677});
    chk("starts", 1, starts);
    chk("op_code", `SFE_OP_PP, op_code);
    chk("op_addr", 24'h000100, op_addr);
    chk("overrun", 0, overrun);
    rdsr(8'h01);
    cmd(1, {`SFE_OP_WREN, 88'h0});
    rdsr(8'h01);
    @(negedge clk) wr_ready = 1'b1;
    for (int i = 0; i < 50 && popped.size() < 8; i++) @(negedge clk);
    if (popped.size() != 8) begin
      errors++;
      final_report();
    end
    for (int i = 0; i < 8; i++) chk("fifo", 24'(i * 17), popped[i]);
    done_pulse();
    rdsr(8'h00);
    $display("program test done");
    cmd(1, {`SFE_OP_WREN, 88'h0});
    cmd(2, {`SFE_OP_WRSR, 8'h1C, 80'h0});
    chk("starts", 2, starts);
    done_pulse();
    rdsr(8'h1C);
    cmd(1, {`SFE_OP_WREN, 88'h0});
    cmd(4, {`SFE_OP_SE, 24'h000000, 64'h0});
    chk("starts", 2, starts);
    rdsr(8'h1E);
    $display("protect test done");
    cmd(5, {`SFE_OP_READ, 24'h000000, 8'h00, 56'h0});
    chk("read", 8'h5A, rx);
    chk("rd_addr", 24'h000001, rd_addr);
    cmd(6, {`SFE_OP_QOUT, 24'h000000, 16'h0, 48'h0});
    chk("quad", 8'hFF, rx);
    cmd(1, {`SFE_OP_PD, 88'h0});
    rdsr(8'hFF);
    cmd(1, {`SFE_OP_REL, 88'h0});
    rdsr(8'h1E);
    $display("read and power-down test done");
    // second reset mid-run, then a write enable inside the lockout
    @(negedge clk) rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    chk("busy", 0, busy);
    chk("oe_n", 24'hF, {l3e, l2e, l1e, l0e});
    chk("lane_out", 24'h0, {l3o, l2o, l1o, l0o});
    cmd(1, {`SFE_OP_WREN, 88'h0});
    rdsr(8'h00);
    $display("reset test done");
    final_report();
  end
endmodule
